// file: rtl/dpsc_regs.vh
// Command, address and timing constants for the DAC power state controller.
`ifndef DPSC_REGS_VH
`define DPSC_REGS_VH
`define DPSC_CMD_WRITE_N 4'h0
`define DPSC_CMD_UPD_N 4'h1
`define DPSC_CMD_WRITE_UPD_ALL 4'h2
`define DPSC_CMD_WRITE_UPD_N 4'h3
`define DPSC_CMD_PD_N 4'h4
`define DPSC_CMD_PD_CHIP 4'h5
`define DPSC_CMD_REF_INT 4'h6
`define DPSC_CMD_REF_EXT 4'h7
`define DPSC_CMD_NOP 4'hF
`define DPSC_ADDR_ALL 4'hF
`define DPSC_ADDR_MAX 4'h7
`define DPSC_CMD_MSB 23
`define DPSC_CMD_LSB 20
`define DPSC_ADR_MSB 19
`define DPSC_ADR_LSB 16
`define DPSC_DAT_MSB 15
`define DPSC_T_PU_NS 10000
`define DPSC_T_PU_BIAS_NS 12000
`define DPSC_CLK_NS 100
`define DPSC_CH_PD_RST 8'hFF
`define DPSC_REF_ON_RST 1'b1
`define DPSC_REF_EXT_RST 1'b0
`define DPSC_BIAS_ON_RST 1'b1
`endif

// file: rtl/dpsc_power_state.v
// Power state tracker for an eight channel DAC, its reference and bias generator.
`timescale 1ns/10ps
`default_nettype none
`include "dpsc_regs.vh"
module dpsc_power_state #(
  parameter NCH = 8,
  parameter DW = 16,
  parameter T_PU_NS = `DPSC_T_PU_NS,
  parameter T_PU_BIAS_NS = `DPSC_T_PU_BIAS_NS
) (
  input wire clock,
  input wire rst_n,
  input wire cmd_valid,
  input wire [23:0] cmd_word,
  output reg [NCH-1:0] ch_pd_reg,
  output reg ref_on_reg,
  output reg bias_on_reg,
  output reg ref_off_ext_reg,
  output reg [NCH-1:0] settle_busy_reg,
  output reg [NCH*DW-1:0] input_data_reg,
  output reg [NCH*DW-1:0] dac_data_reg,
  output reg [NCH-1:0] dac_upd_reg
);
  // Behaviour notes for users of this tracker.
  // Every command takes effect at the clock edge that sees cmd_valid high, one word per pulse.
  // Reserved command codes change nothing; reserved addresses change nothing too, except in a write-and-update-all word, which still updates every channel.
  // The settling flags only model the wake delay; the analog outputs are not modelled here.
  // A channel that is already powered gets no new settling time when it is updated again.
  // The bias state before the waking word picks the delay, because the wake itself turns it on.
  // Timer counts are rounded up, so a clock that does not divide the delay errs on the safe side.
  // Limitation: the timers are 16 bits wide, which bounds the delay at 65535 clock periods.
  // Power-down commands touch no data register; values survive until the next update.
  // The reference wake rule depends on what last turned it off, held in ref_off_ext_reg.
  // After an external-reference select only the internal-reference select brings it back.
  // After a chip power-down any update that powers a channel brings the reference back too.
  // Reset leaves all channels down and the reference on, so bias runs from the start.
  // The first command may arrive at the first clock edge after reset is released.
  // Back to back words are accepted; each one is decoded in the cycle it arrives.
  // Updates to a reserved address write no input register and wake nothing, except write-and-update-all, which still updates and wakes every channel.
  // A write-and-update-all word is the one case where the update mask is wider than the address.
  // The settling flag is a status only; nothing here holds off commands while it is high.
  // The bias flag is derived from the next channel and reference state, so it never lags them.
  // Command words that arrive while reset is low are lost, as the whole state is held.

  // Counts round up so the settling wait is never shorter than specified.
  localparam integer PU_CYC_INT = (T_PU_NS + `DPSC_CLK_NS - 1) / `DPSC_CLK_NS;
  localparam integer PU_BIAS_CYC_INT = (T_PU_BIAS_NS + `DPSC_CLK_NS - 1) / `DPSC_CLK_NS;
  localparam [15:0] PU_CYC = PU_CYC_INT[15:0];
  localparam [15:0] PU_BIAS_CYC = PU_BIAS_CYC_INT[15:0];

  // Selects the channel mask of an address; reserved addresses select nothing.
  function [NCH-1:0] sel_mask;
    input [3:0] adr;
    begin
      if (adr == `DPSC_ADDR_ALL) begin
        sel_mask = {NCH{1'b1}};
      end else if (adr <= `DPSC_ADDR_MAX) begin
        sel_mask = {{(NCH-1){1'b0}}, 1'b1} << adr;
      end else begin
        sel_mask = {NCH{1'b0}};
      end
    end
  endfunction

  // Fields of the received word; the data field is read only by write commands.
  wire [3:0] cmd = cmd_word[`DPSC_CMD_MSB:`DPSC_CMD_LSB];
  wire [3:0] adr = cmd_word[`DPSC_ADR_MSB:`DPSC_ADR_LSB];
  wire [DW-1:0] dat = cmd_word[`DPSC_DAT_MSB:0];
  wire [NCH-1:0] sel = sel_mask(adr);

  // True for codes that load an input register; the case keeps reserved codes inert.
  function cmd_is_write;
    input [3:0] code;
    begin
      case (code)
        `DPSC_CMD_WRITE_N: cmd_is_write = 1'b1;
        `DPSC_CMD_WRITE_UPD_ALL: cmd_is_write = 1'b1;
        `DPSC_CMD_WRITE_UPD_N: cmd_is_write = 1'b1;
        default: cmd_is_write = 1'b0;
      endcase
    end
  endfunction

  // True for codes that copy into the active registers and so power channels up.
  function cmd_is_upd;
    input [3:0] code;
    begin
      case (code)
        `DPSC_CMD_UPD_N: cmd_is_upd = 1'b1;
        `DPSC_CMD_WRITE_UPD_ALL: cmd_is_upd = 1'b1;
        `DPSC_CMD_WRITE_UPD_N: cmd_is_upd = 1'b1;
        default: cmd_is_upd = 1'b0;
      endcase
    end
  endfunction

  // Decoded command classes.
  // Write and update codes only
  wire is_write = cmd_valid && cmd_is_write(cmd);
  wire is_upd = cmd_valid && cmd_is_upd(cmd);
  wire [NCH-1:0] write_mask = is_write ? sel : {NCH{1'b0}};
  // Write-and-update-all loads only the addressed input registers but updates every channel.
  wire [NCH-1:0] upd_mask = !is_upd ? {NCH{1'b0}} :
    (cmd == `DPSC_CMD_WRITE_UPD_ALL) ? {NCH{1'b1}} : sel;
  wire [NCH-1:0] pd_mask = (cmd_valid && cmd == `DPSC_CMD_PD_N) ? sel : {NCH{1'b0}};
  wire pd_chip = cmd_valid && cmd == `DPSC_CMD_PD_CHIP;
  wire ref_int = cmd_valid && cmd == `DPSC_CMD_REF_INT;
  wire ref_ext = cmd_valid && cmd == `DPSC_CMD_REF_EXT;
  // Only a chip power-down leaves the reference wakeable by an update word.
  // External flag blocks
  wire ref_upd_wake = !ref_on_reg && !ref_off_ext_reg;
  // Only channels that were down start a timer; an update to a powered channel leaves its timer alone.
  wire [NCH-1:0] wake_mask = upd_mask & ch_pd_reg;

  // Next-state values, settled by the combinational process below.
  reg [NCH-1:0] ch_pd_next;
  reg ref_on_next;
  reg ref_off_ext_next;
  reg bias_on_next;

  // Next power state of channels and reference.
  always @* begin
    // Hold by default; at most one command class applies per word.
    ch_pd_next = ch_pd_reg;
    ref_on_next = ref_on_reg;
    ref_off_ext_next = ref_off_ext_reg;
    ch_pd_next = ch_pd_next | pd_mask;
    ch_pd_next = ch_pd_next & ~upd_mask;
    if (pd_chip) begin
      ch_pd_next = {NCH{1'b1}};
      ref_on_next = 1'b0;
      ref_off_ext_next = 1'b0;
    end else if (ref_ext) begin
      ref_on_next = 1'b0;
      ref_off_ext_next = 1'b1;
    end else if (ref_int) begin
      ref_on_next = 1'b1;
      ref_off_ext_next = 1'b0;
    end else if (ref_upd_wake && (|upd_mask)) begin
      ref_on_next = 1'b1;
    end
    // Bias is off only when nothing that needs it is on after this word.
    // Bias follows total shutdown
    bias_on_next = ref_on_next || !(&ch_pd_next);
  end

  // Power state registers.
  // Reset leaves every channel down while the reference and bias stay on.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ch_pd_reg <= `DPSC_CH_PD_RST;
      ref_on_reg <= `DPSC_REF_ON_RST;
      ref_off_ext_reg <= `DPSC_REF_EXT_RST;
      bias_on_reg <= `DPSC_BIAS_ON_RST;
    end else begin
      ch_pd_reg <= ch_pd_next;
      ref_on_reg <= ref_on_next;
      ref_off_ext_reg <= ref_off_ext_next;
      bias_on_reg <= bias_on_next;
    end
  end

  // Per-channel data registers and settling timers.
  // Each channel keeps its own timer, so channels woken at different times settle independently.
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg [15:0] tmr_reg;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          input_data_reg[g*DW +: DW] <= {DW{1'b0}};
          dac_data_reg[g*DW +: DW] <= {DW{1'b0}};
          dac_upd_reg[g] <= 1'b0;
        end else begin
          // One-cycle update pulse, so a converter downstream can latch the new code.
          dac_upd_reg[g] <= upd_mask[g];
          if (write_mask[g]) begin
            input_data_reg[g*DW +: DW] <= dat;
          end
          if (upd_mask[g]) begin
            // Write-and-update copies the fresh word, not the stale input register.
            dac_data_reg[g*DW +: DW] <= write_mask[g] ? dat : input_data_reg[g*DW +: DW];
          end
        end
      end
      // The longer wait applies when bias had been shut before this wake.
      // A wake in mid-count restarts the timer; back to back updates do not, as only the first finds the channel down.
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          tmr_reg <= 16'h0000;
          settle_busy_reg[g] <= 1'b0;
        end else if (wake_mask[g]) begin
          tmr_reg <= (bias_on_reg ? PU_CYC : PU_BIAS_CYC) - 16'h0001;
          settle_busy_reg[g] <= 1'b1;
        end else if (tmr_reg != 16'h0000) begin
          tmr_reg <= tmr_reg - 16'h0001;
        end else begin
          settle_busy_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // dpsc_power_state
`default_nettype wire

// file: tb/dpsc_chk_properties.sv
// Checker of power state relations at the tracker ports.
`timescale 1ns/10ps
`default_nettype none
module dpsc_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [23:0] cmd_word,
  input wire logic [7:0] ch_pd_reg,
  input wire logic ref_on_reg,
  input wire logic bias_on_reg,
  input wire logic ref_off_ext_reg,
  input wire logic [7:0] settle_busy_reg
);
  // Reserved code 4'hE stands for no command, so idle cycles match nothing.
  wire [3:0] c = cmd_valid ? cmd_word[23:20] : 4'hE;
  wire w0 = c == 4'h3 && cmd_word[19:16] == 4'h0;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_up; w0 |=> !ch_pd_reg[0]; endproperty
  a_up: assert property (p_up) else $error("wake");
  property p_sb; w0 && ch_pd_reg[0] |=> settle_busy_reg[0]; endproperty
  a_sb: assert property (p_sb) else $error("settle");
  property p_cp; c == 4'h5 |=> !bias_on_reg && !ref_on_reg && &ch_pd_reg; endproperty
  a_cp: assert property (p_cp) else $error("chip");
  property p_ex; !ref_on_reg && ref_off_ext_reg && c != 4'h6 |=> !ref_on_reg; endproperty
  a_ex: assert property (p_ex) else $error("ext");
  property p_rw; !ref_on_reg && !ref_off_ext_reg && w0 |=> ref_on_reg; endproperty
  a_rw: assert property (p_rw) else $error("ref");
  property p_fl; c == 4'h7 |=> ref_off_ext_reg && !ref_on_reg; endproperty
  a_fl: assert property (p_fl) else $error("flag");
  property p_pa; c == 4'h4 && cmd_word[19:16] == 4'hF |=> &ch_pd_reg; endproperty
  a_pa: assert property (p_pa) else $error("pd");
  property p_np; c == 4'h0 || c == 4'hF |=> $stable(ch_pd_reg) && $stable(ref_on_reg); endproperty
  a_np: assert property (p_np) else $error("nop");
  cover property (c == 4'h5);
  cover property (c == 4'h7);
  cover property (w0 && !bias_on_reg);
endmodule // dpsc_chk
bind dpsc_power_state dpsc_chk u_chk (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
  .ch_pd_reg(ch_pd_reg), .ref_on_reg(ref_on_reg), .bias_on_reg(bias_on_reg), .ref_off_ext_reg(ref_off_ext_reg),
  .settle_busy_reg(settle_busy_reg));
`default_nettype wire

// file: tb/dpsc_cmd_src.sv
// Command word source standing in for the serial bus master.
`timescale 1ns/10ps
`default_nettype none
module dpsc_cmd_src (
  input wire logic clock,
  output var logic cmd_valid = 1'b0,
  output var logic [23:0] cmd_word = 24'h000000
);
  // legal codes only
  // One pulse per word; the word is inverted once released so stale data never matches.
  task send(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    @(negedge clock);
    cmd_valid <= 1'b1;
    cmd_word <= {c, a, d};
    @(negedge clock);
    cmd_valid <= 1'b0;
    cmd_word <= ~{c, a, d};
  endtask
endmodule // dpsc_cmd_src
`default_nettype wire

// file: tb/dpsc_power_state_tb_top.sv
// Self-checking bench of the DAC power state tracker.
`timescale 1ns/10ps
`default_nettype none
module dpsc_power_state_tb_top;
  logic clock, rst_n, cmd_valid, ref_on_reg, bias_on_reg, ref_off_ext_reg;
  logic [23:0] cmd_word;
  logic [7:0] ch_pd_reg, settle_busy_reg, dac_upd_reg;
  logic [127:0] dac_data_reg, input_data_reg;
  logic [15:0] st;
  int fails = 0, total_checks = 0;
  // State packed as flag, bias, reference and channel bits for compact compares.
  assign st = {ref_off_ext_reg, bias_on_reg, ref_on_reg, 5'h00, ch_pd_reg};
  // Delays shortened to 10 and 12 cycles to keep the run brief.
  dpsc_power_state #(.T_PU_NS(1000), .T_PU_BIAS_NS(1200)) dut (.clock(clock), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .ch_pd_reg(ch_pd_reg), .ref_on_reg(ref_on_reg),
    .bias_on_reg(bias_on_reg), .ref_off_ext_reg(ref_off_ext_reg), .settle_busy_reg(settle_busy_reg),
    .input_data_reg(input_data_reg), .dac_data_reg(dac_data_reg), .dac_upd_reg(dac_upd_reg));
  dpsc_cmd_src src (.clock(clock), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  task chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Counts settling cycles of channel zero over a bounded span.
  task busy(input logic [15:0] e);
    logic [15:0] n;
    n = 16'h0000;
    repeat (20) begin
      n = n + {15'h0000, settle_busy_reg[0] === 1'b1};
      @(negedge clock);
    end
    chk(n, e);
  endtask
  task s_chip;
    src.send(4'h5, 4'h0, 16'hFFFF);
    chk(st, 16'h00FF);
    chk(dac_data_reg[15:0], 16'h1234);
    chk(input_data_reg[15:0], 16'h1234);
    src.send(4'h0, 4'h1, 16'h5555);
    chk(input_data_reg[31:16], 16'h5555);
    chk(dac_data_reg[31:16], 16'h0000);
    src.send(4'hF, 4'h0, 16'h0000);
    chk(st, 16'h00FF);
    src.send(4'h3, 4'h0, 16'h0777);
    chk(st, 16'h60FE);
    busy(16'h000C);
  endtask
  task s_ext;
    src.send(4'h7, 4'h0, 16'h0000);
    chk(st, 16'hC0FE);
    src.send(4'h2, 4'h1, 16'h0ABC);
    chk(st, 16'hC000);
    chk(dac_data_reg[31:16], 16'h0ABC);
    chk({8'h00, dac_upd_reg}, 16'h00FF);
    chk({8'h00, settle_busy_reg}, 16'h00FE);
    src.send(4'h4, 4'hF, 16'hBEEF);
    chk(st, 16'h80FF);
    chk(dac_data_reg[15:0], 16'h0777);
    chk(input_data_reg[15:0], 16'h0777);
    src.send(4'h6, 4'h0, 16'h0000);
    chk({15'h0000, ref_on_reg}, 16'h0001);
  endtask
  // Reset state, then the first wake of channel zero with bias running.
  task s_wake;
    chk(st, 16'h60FF);
    src.send(4'h3, 4'h0, 16'h1234);
    chk(st, 16'h60FE);
    chk({8'h00, dac_upd_reg}, 16'h0001);
    chk(dac_data_reg[15:0], 16'h1234);
    busy(16'h000A);
  endtask
  // A plain write, then an update that copies the held word and powers the channel.
  task s_upd;
    src.send(4'h0, 4'h2, 16'h4321);
    chk(dac_data_reg[47:32], 16'h0000);
    chk({8'h00, dac_upd_reg}, 16'h0000);
    src.send(4'h1, 4'h2, 16'hDEAD);
    chk(dac_data_reg[47:32], 16'h4321);
    chk(input_data_reg[47:32], 16'h4321);
    chk(st, 16'h60FB);
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    s_wake;
    s_chip;
    s_ext;
    s_upd;
    finish_test;
  end
endmodule // dpsc_power_state_tb_top
`default_nettype wire
